// *** shared/acm_framer_pkg.sv ***
/*
 constants, types and shared decoding for the packet slicer/merger.
 assumes one clock domain (mclk) and a synchronous active-high reset.
*/
// Behaviour
// R1 - a packet length above 64K bits is not packetized; such data is framed as a continuous stream.
// R2 - the sender computes a CRC-8 over each packet's data and puts it in place of the next packet's sync byte.
// R3 - a frame only carries data of its own protection level plus the CRC values belonging to that data.
// R4 - a packet crossing a frame edge is split right after its CRC byte, so the CRC closes the earlier frame; the code never splits, it pads the frame.
// R5 - spare room in a frame is filled with padding rather than null packets.
// R6 - after a lost frame, a pointer equal to packet length minus 8 means a full packet and its CRC precede it; keep them.
// R7 - after a lost frame, any other pointer value means the data before it belongs to the lost frame; drop it.
// R8 - a CRC byte that ends a frame checks the packet before it even if the next frame is lost.
// R9 - good frames of the selected stream are treated as contiguous whatever other frames came between.
// R10 - with a nonzero pointer, the bytes before it are parsed with the packet length of the previous good frame.
// R11 - a frame counts as good on a passing header CRC, optionally also a passing BCH decode.
// R12 - the sender polls the level queues in cyclic order and closes a short frame after a timeout.
// R13 - each level may be served for a software-set number of consecutive frames per polling turn.
// R14 - there is one input queue per protection level, 24 here out of at most 28.
// R15 - each queue holds twice the largest data field, and no more, since it sits in the adaptive loop.
// R16 - each frame's data field is exactly the information size configured for its level.
// R17 - timeout and weights are software registers that take effect from the next polling turn.
package acm_framer_pkg;
   // ***************************************
   // sizes
   // ***************************************
   localparam int MAX_LEVELS = 28;
   localparam int NUM_LEVELS = 24;
   localparam int DF_MAX_BYTES = 256;
   localparam int QUEUE_BYTES = 2 * DF_MAX_BYTES;
   localparam int QPTR_W = 9;
   localparam int QCNT_W = 10;
   localparam int OUT_FIFO_DEPTH = 8;
   localparam logic [16:0] UPL_MAX_BITS = 17'h10000;
   localparam logic [7:0] CRC8_POLY = 8'hD5;
   localparam logic [7:0] PAD_BYTE = 8'h00;

   // ***************************************
   // register map and reset values
   // ***************************************
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_UPL = 12'h004;
   localparam logic [11:0] OFS_TIMEOUT = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_RX_STREAM = 12'h010;
   localparam logic [11:0] OFS_RX_PKTS = 12'h014;
   localparam logic [11:0] OFS_RX_ERRS = 12'h018;
   localparam logic [11:0] OFS_WEIGHT_BASE = 12'h100;
   localparam logic [11:0] OFS_DFL_BASE = 12'h200;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_USE_BCH = 2;
   localparam logic [2:0] CONTROL_RST = 3'h0;
   localparam logic [16:0] UPL_RST = 17'h005E0;
   localparam logic [15:0] TIMEOUT_RST = 16'h0400;
   localparam logic [3:0] WEIGHT_RST = 4'h1;
   localparam logic [15:0] DFL_RST = 16'h0080;
   localparam logic [7:0] STREAM_RST = 8'h00;

   // ***************************************
   // types
   // ***************************************
   typedef enum logic [1:0] {TX_POLL = 2'b00, TX_DATA = 2'b01, TX_PAD = 2'b11} tx_state_t;
   typedef struct packed {logic [7:0] data; logic last;} tx_byte_t;
   typedef struct packed {
      logic [4:0] level;
      logic [16:0] user_packet_length;
      logic [15:0] data_field_length;
      logic [15:0] sync_distance_pointer;
   } frame_desc_t;
   typedef struct packed {
      logic [7:0] stream_id;
      logic [16:0] user_packet_length;
      logic [15:0] data_field_length;
      logic [15:0] sync_distance_pointer;
      logic hdr_crc_ok;
      logic bch_ok;
   } rx_hdr_t;

   function automatic logic [7:0] crc8_next(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      logic fb;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         fb = c[7] ^ data[i];
         c = {c[6:0], 1'b0};
         if (fb) begin
            c = c ^ CRC8_POLY;
         end
      end
      return c;
   endfunction
endpackage

// *** rtl/acm_packet_slicer_merger.sv ***
/*
 packet slicer (transmit) and packet merger (receive) with apb registers and an
 8-word output fifo. assumes an apb master on mclk and byte-wide partners on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

// ***************************************
// output fifo
// ***************************************
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_wr;
   logic do_rd;

   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(do_wr);
         rd_ptr <= rd_ptr + (AW+1)'(do_rd);
      end
   end
endmodule // byte_fifo

// ***************************************
// slicer / merger top
// ***************************************
module acm_packet_slicer_merger (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // per-level input from the router
   input wire logic [4:0] in_level,
   input wire logic [7:0] in_byte,
   input wire logic in_valid,
   output logic [acm_framer_pkg::NUM_LEVELS-1:0] in_ready,
   // framed output toward the modulator
   output acm_framer_pkg::tx_byte_t tx_out,
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output acm_framer_pkg::frame_desc_t tx_desc,
   output logic tx_desc_valid,
   // decoded frames from the demodulator
   input wire acm_framer_pkg::rx_hdr_t rx_hdr,
   input wire logic rx_hdr_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_byte_valid,
   // rebuilt packet stream
   output logic [7:0] rx_out_byte,
   output logic rx_out_valid,
   output logic rx_out_sop,
   output logic rx_pkt_done,
   output logic rx_pkt_crc_ok
);
   localparam int NL = acm_framer_pkg::NUM_LEVELS;

   function automatic logic in_region(input logic [11:0] addr, input logic [11:0] base);
      return addr[11:8] == base[11:8] && addr[1:0] == 2'b00 && 32'(addr[7:2]) < NL;
   endfunction

   // ***************************************
   // registers
   // ***************************************
   logic [2:0] control;
   logic [16:0] upl_cfg;
   logic [15:0] timeout_cfg;
   logic [15:0] timeout_sh;
   logic [7:0] stream_sel;
   logic [31:0] rx_pkts;
   logic [31:0] rx_errs;
   logic [3:0] weight [NL];
   logic [3:0] weight_sh [NL];
   logic [15:0] dfl_bytes [NL];
   logic access;
   logic wr_en;
   logic hit;
   logic [4:0] reg_idx;
   logic [31:0] rd_value;
   acm_framer_pkg::tx_state_t state;
   logic [4:0] lvl;
   logic rx_lost;
   logic rx_have_prev;

   assign access = psel && penable && !pready;
   assign wr_en = access && pwrite;
   assign reg_idx = paddr[6:2];

   always_comb begin
      hit = 1'b1;
      rd_value = 32'h0000_0000;
      if (in_region(paddr, acm_framer_pkg::OFS_WEIGHT_BASE)) begin
         rd_value = {28'h0, weight[reg_idx]};
      end else if (in_region(paddr, acm_framer_pkg::OFS_DFL_BASE)) begin
         rd_value = {16'h0, dfl_bytes[reg_idx]};
      end else begin
         unique case (paddr)
            acm_framer_pkg::OFS_CONTROL: rd_value = {29'h0, control};
            acm_framer_pkg::OFS_UPL: rd_value = {15'h0, upl_cfg};
            acm_framer_pkg::OFS_TIMEOUT: rd_value = {16'h0, timeout_cfg};
            acm_framer_pkg::OFS_STATUS: rd_value = {22'h0, rx_lost, rx_have_prev, state, 1'b0, lvl};
            acm_framer_pkg::OFS_RX_STREAM: rd_value = {24'h0, stream_sel};
            acm_framer_pkg::OFS_RX_PKTS: rd_value = rx_pkts;
            acm_framer_pkg::OFS_RX_ERRS: rd_value = rx_errs;
            default: hit = 1'b0;
         endcase
      end
   end

   // one wait state: answer registered in the cycle after the access phase opens
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access && !hit;
         if (access && !pwrite) begin
            prdata <= rd_value;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         control <= acm_framer_pkg::CONTROL_RST;
         upl_cfg <= acm_framer_pkg::UPL_RST;
         timeout_cfg <= acm_framer_pkg::TIMEOUT_RST;
         stream_sel <= acm_framer_pkg::STREAM_RST;
      end else if (wr_en) begin
         if (paddr == acm_framer_pkg::OFS_CONTROL) control <= pwdata[2:0];
         if (paddr == acm_framer_pkg::OFS_UPL) upl_cfg <= pwdata[16:0];
         if (paddr == acm_framer_pkg::OFS_TIMEOUT) timeout_cfg <= pwdata[15:0]; // [R17]
         if (paddr == acm_framer_pkg::OFS_RX_STREAM) stream_sel <= pwdata[7:0];
      end
   end

   // ***************************************
   // level queues, one per protection level
   // ***************************************
   // depth is twice the largest data field; kept small since it adds loop delay
   logic [7:0] qmem [NL*acm_framer_pkg::QUEUE_BYTES]; // [R15]
   logic [acm_framer_pkg::QPTR_W-1:0] q_wr [NL];
   logic [acm_framer_pkg::QPTR_W-1:0] q_rd [NL];
   logic [acm_framer_pkg::QCNT_W-1:0] q_cnt [NL];
   logic [15:0] age [NL];
   logic push_ok;
   logic pop;
   logic frame_close;
   logic [7:0] rd_byte;

   assign push_ok = in_valid && (32'(in_level) < NL) && in_ready[in_level]; // [R14]
   assign rd_byte = qmem[{lvl, q_rd[lvl]}];

   always_ff @(posedge mclk) begin
      if (push_ok) begin
         qmem[{in_level, q_wr[in_level]}] <= in_byte;
      end
   end

   generate
      for (genvar i = 0; i < NL; i++) begin : g_level
         logic push_i;
         logic pop_i;
         logic [acm_framer_pkg::QCNT_W-1:0] next_cnt;
         assign push_i = push_ok && in_level == 5'(i);
         assign pop_i = pop && lvl == 5'(i);
         assign next_cnt = q_cnt[i] + acm_framer_pkg::QCNT_W'(push_i) - acm_framer_pkg::QCNT_W'(pop_i);

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               q_wr[i] <= '0;
               q_rd[i] <= '0;
               q_cnt[i] <= '0;
               in_ready[i] <= 1'b1;
            end else begin
               q_wr[i] <= q_wr[i] + acm_framer_pkg::QPTR_W'(push_i);
               q_rd[i] <= q_rd[i] + acm_framer_pkg::QPTR_W'(pop_i);
               q_cnt[i] <= next_cnt;
               // margin of one since the router sees ready a cycle late
               in_ready[i] <= 32'(next_cnt) < acm_framer_pkg::QUEUE_BYTES - 1;
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst || q_cnt[i] == '0 || (frame_close && lvl == 5'(i))) begin
               age[i] <= 16'h0000;
            end else if (age[i] != 16'hFFFF) begin
               age[i] <= age[i] + 16'h0001;
            end
         end

         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               weight[i] <= acm_framer_pkg::WEIGHT_RST;
               dfl_bytes[i] <= acm_framer_pkg::DFL_RST;
            end else if (wr_en) begin
               if (paddr == acm_framer_pkg::OFS_WEIGHT_BASE + 12'(4*i)) weight[i] <= pwdata[3:0]; // [R17]
               if (paddr == acm_framer_pkg::OFS_DFL_BASE + 12'(4*i)) dfl_bytes[i] <= pwdata[15:0]; // [R16]
            end
         end
      end
   endgenerate

   // ***************************************
   // slicer
   // ***************************************
   logic [3:0] turn_cnt;
   logic [15:0] df_left;
   logic [15:0] unit_pos;
   logic [15:0] frame_unit;
   logic frame_pkt;
   logic [15:0] used;
   logic [7:0] crc_tx;
   logic upl_ok;
   logic [15:0] unit_cfg;
   logic [15:0] cnt_l;
   logic [15:0] df_l;
   logic [3:0] eff_w;
   logic go;
   logic push;
   logic is_pad;
   acm_framer_pkg::tx_byte_t fifo_in;
   logic fifo_in_ready;

   // long constant packets fall back to continuous framing
   assign upl_ok = upl_cfg != 17'h0 && upl_cfg <= acm_framer_pkg::UPL_MAX_BITS && upl_cfg[2:0] == 3'h0; // [R1]
   assign unit_cfg = upl_ok ? {2'b00, upl_cfg[16:3]} : 16'h0001;
   assign cnt_l = 16'(q_cnt[lvl]);
   assign df_l = dfl_bytes[lvl];
   assign eff_w = weight_sh[lvl] == 4'h0 ? 4'h1 : weight_sh[lvl];
   assign go = control[acm_framer_pkg::CTRL_TX_EN] && df_l != 16'h0 && cnt_l >= unit_cfg
             && (cnt_l >= df_l || age[lvl] >= timeout_sh); // [R12]
   assign frame_close = push && fifo_in.last;

   always_comb begin
      push = 1'b0;
      pop = 1'b0;
      is_pad = 1'b0;
      fifo_in.data = rd_byte;
      fifo_in.last = df_left == 16'h0001;
      if (state == acm_framer_pkg::TX_DATA && fifo_in_ready) begin
         if (frame_pkt) begin
            if (unit_pos == 16'h0) begin
               pop = df_left >= frame_unit && cnt_l >= frame_unit; // [R3] sync slot dropped
            end else if (unit_pos < frame_unit) begin
               push = 1'b1;
               pop = 1'b1;
            end else begin
               push = 1'b1;
               fifo_in.data = crc_tx; // [R2] [R4]
            end
         end else begin
            push = cnt_l != 16'h0;
            pop = push;
         end
      end else if (state == acm_framer_pkg::TX_PAD && fifo_in_ready) begin
         push = 1'b1;
         is_pad = 1'b1;
         fifo_in.data = acm_framer_pkg::PAD_BYTE; // [R5]
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= acm_framer_pkg::TX_POLL;
         lvl <= 5'h00;
         turn_cnt <= 4'h0;
      end else begin
         unique case (state)
            acm_framer_pkg::TX_POLL: begin
               if (go && turn_cnt < eff_w) begin // [R13]
                  state <= acm_framer_pkg::TX_DATA;
                  turn_cnt <= turn_cnt + 4'h1;
               end else begin
                  turn_cnt <= 4'h0;
                  lvl <= (32'(lvl) == NL - 1) ? 5'h00 : lvl + 5'h01; // [R12]
               end
            end
            acm_framer_pkg::TX_DATA: begin
               if (frame_close) begin
                  state <= acm_framer_pkg::TX_POLL;
               end else if (fifo_in_ready && !push && !pop) begin
                  state <= acm_framer_pkg::TX_PAD;
               end
            end
            acm_framer_pkg::TX_PAD: begin
               if (frame_close) begin
                  state <= acm_framer_pkg::TX_POLL;
               end
            end
         endcase
      end
   end

   // new timeout and weights apply only when the poll wraps round
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         timeout_sh <= acm_framer_pkg::TIMEOUT_RST;
         for (int i = 0; i < NL; i++) weight_sh[i] <= acm_framer_pkg::WEIGHT_RST;
      end else if (state == acm_framer_pkg::TX_POLL && !(go && turn_cnt < eff_w) && 32'(lvl) == NL - 1) begin
         timeout_sh <= timeout_cfg; // [R17]
         for (int i = 0; i < NL; i++) weight_sh[i] <= weight[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         df_left <= 16'h0;
         unit_pos <= 16'h0;
         frame_unit <= 16'h1;
         frame_pkt <= 1'b0;
         used <= 16'h0;
         crc_tx <= 8'h00;
      end else if (state == acm_framer_pkg::TX_POLL) begin
         df_left <= df_l; // [R16]
         unit_pos <= 16'h0;
         frame_unit <= unit_cfg;
         frame_pkt <= upl_ok;
         used <= 16'h0;
      end else begin
         if (push) df_left <= df_left - 16'h1;
         if (push && !is_pad) used <= used + 16'h1;
         if (state == acm_framer_pkg::TX_DATA && frame_pkt && (push || pop)) begin
            if (unit_pos == 16'h0) begin
               unit_pos <= 16'h1;
               crc_tx <= 8'h00;
            end else if (unit_pos < frame_unit) begin
               unit_pos <= unit_pos + 16'h1;
               crc_tx <= acm_framer_pkg::crc8_next(crc_tx, rd_byte); // [R2]
            end else begin
               unit_pos <= 16'h0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_desc_valid <= 1'b0;
         tx_desc <= '0;
      end else begin
         tx_desc_valid <= frame_close;
         if (frame_close) begin
            tx_desc.level <= lvl;
            tx_desc.user_packet_length <= frame_pkt ? upl_cfg : 17'h0;
            tx_desc.data_field_length <= {used[12:0] + 13'(!is_pad), 3'b000};
            tx_desc.sync_distance_pointer <= (frame_pkt && (used != 16'h0 || !is_pad)) ? 16'(upl_cfg - 17'h8) : 16'h0;
         end
      end
   end

   byte_fifo #(
      .WIDTH($bits(acm_framer_pkg::tx_byte_t)),
      .DEPTH(acm_framer_pkg::OUT_FIFO_DEPTH)
   ) u_out_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_data(fifo_in),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .out_data(tx_out),
      .out_valid(tx_out_valid),
      .out_ready(tx_out_ready)
   );

   // ***************************************
   // merger
   // ***************************************
   logic rx_good;
   logic rx_cont;
   logic [15:0] rx_df_left;
   logic [15:0] rx_skip;
   logic [15:0] rx_pos;
   logic [13:0] cur_upl;
   logic [13:0] frame_upl;
   logic [13:0] prev_upl;
   logic [7:0] crc_rx;
   logic hdr_ok;
   logic take;

   assign hdr_ok = rx_hdr.hdr_crc_ok && (!control[acm_framer_pkg::CTRL_USE_BCH] || rx_hdr.bch_ok); // [R11]
   assign take = rx_byte_valid && rx_good && rx_df_left != 16'h0;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rx_good <= 1'b0;
         rx_cont <= 1'b0;
         rx_lost <= 1'b1;
         rx_have_prev <= 1'b0;
         rx_df_left <= 16'h0;
         rx_skip <= 16'h0;
         rx_pos <= 16'h0;
         cur_upl <= 14'h0;
         frame_upl <= 14'h0;
         prev_upl <= 14'h0;
         crc_rx <= 8'h00;
      end else if (rx_hdr_valid) begin
         rx_good <= 1'b0;
         if (!hdr_ok) begin
            rx_lost <= 1'b1;
         end else if (rx_hdr.stream_id == stream_sel && control[acm_framer_pkg::CTRL_RX_EN]) begin // [R9]
            rx_good <= 1'b1;
            rx_lost <= 1'b0;
            rx_have_prev <= 1'b1;
            rx_df_left <= {3'b000, rx_hdr.data_field_length[15:3]};
            rx_cont <= rx_hdr.user_packet_length == 17'h0;
            frame_upl <= rx_hdr.user_packet_length[16:3];
            prev_upl <= rx_hdr.user_packet_length[16:3];
            if (rx_lost || !rx_have_prev) begin
               rx_pos <= 16'h0;
               crc_rx <= 8'h00;
               cur_upl <= rx_hdr.user_packet_length[16:3];
               if (rx_hdr.sync_distance_pointer == 16'(rx_hdr.user_packet_length - 17'h8)) begin
                  rx_skip <= 16'h0; // [R6]
               end else begin
                  rx_skip <= {3'b000, rx_hdr.sync_distance_pointer[15:3]} + 16'h1; // [R7]
               end
            end else begin
               rx_skip <= 16'h0;
               cur_upl <= prev_upl; // [R10]
            end
         end
      end else if (take) begin
         rx_df_left <= rx_df_left - 16'h1;
         if (rx_skip != 16'h0) begin
            rx_skip <= rx_skip - 16'h1;
         end else if (!rx_cont) begin
            if (rx_pos + 16'h1 < {2'b00, cur_upl}) begin
               rx_pos <= rx_pos + 16'h1;
               crc_rx <= acm_framer_pkg::crc8_next(crc_rx, rx_byte);
            end else begin
               rx_pos <= 16'h0;
               crc_rx <= 8'h00;
               cur_upl <= frame_upl;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rx_out_byte <= 8'h00;
         rx_out_valid <= 1'b0;
         rx_out_sop <= 1'b0;
         rx_pkt_done <= 1'b0;
         rx_pkt_crc_ok <= 1'b0;
         rx_pkts <= 32'h0;
         rx_errs <= 32'h0;
      end else begin
         rx_out_valid <= 1'b0;
         rx_out_sop <= 1'b0;
         rx_pkt_done <= 1'b0;
         if (!rx_hdr_valid && take && rx_skip == 16'h0) begin
            if (rx_cont || rx_pos + 16'h1 < {2'b00, cur_upl}) begin
               rx_out_byte <= rx_byte;
               rx_out_valid <= 1'b1;
               rx_out_sop <= !rx_cont && rx_pos == 16'h0;
            end else begin
               // closing crc checks its packet even if the next frame never comes
               rx_pkt_done <= 1'b1; // [R8]
               rx_pkt_crc_ok <= rx_byte == crc_rx;
               rx_pkts <= rx_pkts + 32'h1;
               if (rx_byte != crc_rx) rx_errs <= rx_errs + 32'h1;
            end
         end
      end
   end
endmodule // acm_packet_slicer_merger

`default_nettype wire

// *** bench/acm_monitor.sv ***
/* port checker for the slicer/merger top. assumes one clock, mclk, and sys_rst. */
`timescale 1ns/10ps
`default_nettype none
module acm_monitor (
   // clock, reset, apb
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // streams
   input wire acm_framer_pkg::tx_byte_t tx_out,
   input wire logic tx_out_valid,
   input wire logic tx_out_ready,
   input wire acm_framer_pkg::frame_desc_t tx_desc,
   input wire logic tx_desc_valid,
   input wire logic rx_byte_valid,
   input wire logic rx_out_valid,
   input wire logic rx_out_sop,
   input wire logic rx_pkt_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   a_one_wait: assert property (s_wait |=> s_answer) else $error("apb answer timing wrong");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_tx_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out))
      else $error("output byte moved while stalled");
   a_desc_level: assert property (tx_desc_valid |-> tx_desc.level < 5'h18) else $error("bad level");
   a_desc_sync_distance_pointer: assert property (tx_desc_valid && tx_desc.user_packet_length != 0 && tx_desc.data_field_length != 0
      |-> tx_desc.sync_distance_pointer == tx_desc.user_packet_length[15:0] - 16'h0008) else $error("pointer not at crc");
   a_dfl_bound: assert property (tx_desc_valid |-> tx_desc.data_field_length <= 16'h0800) else $error("field too long");
   a_out_cause: assert property (rx_out_valid |-> $past(rx_byte_valid)) else $error("byte from nowhere");
   a_done_cause: assert property (rx_pkt_done |-> $past(rx_byte_valid) && !rx_out_valid)
      else $error("check without crc byte");
   a_sop_valid: assert property (rx_out_sop |-> rx_out_valid) else $error("start without byte");
endmodule // acm_monitor
bind acm_packet_slicer_merger acm_monitor mon (.*);
`default_nettype wire

// *** bench/tx_sink.sv ***
/* modulator-side sink for framed bytes. assumes the bench chooses when it stalls. */
`timescale 1ns/10ps
`default_nettype none
module tx_sink (
   // control
   input wire logic stall,
   // handshake
   output logic tx_out_ready
);
   // stalls come straight through so backpressure hits any cycle
   assign tx_out_ready = !stall;
endmodule // tx_sink
`default_nettype wire

// *** bench/tb_top.sv ***
/* self-checking bench for the slicer/merger. assumes the monitor is bound to the top. */
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, in_valid, tx_out_valid, rx_hdr_valid;
   logic rx_byte_valid, rx_out_valid, rx_pkt_done, rx_pkt_crc_ok, stall, tx_out_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [4:0] in_level;
   logic [7:0] in_byte, rx_byte, rx_out_byte, a, b;
   logic [23:0] in_ready;
   logic [32:0] e;
   acm_framer_pkg::tx_byte_t tx_out;
   acm_framer_pkg::rx_hdr_t rx_hdr;
   logic [32:0] aq[$], tq[$], rq[$], cq[$];
   logic [7:0] fb[$];
   logic [11:0] ra[6] = '{12'h000, 12'h004, 12'h008, 12'h100, 12'h200, 12'h0FC};
   logic [32:0] rv[6] = '{33'h0, 33'h5E0, 33'h400, 33'h1, 33'h80, 33'h1_0000_0000};
   int seed = 23, mismatches = 0, n_compared = 0, cyc = 0;
   acm_packet_slicer_merger uut (.*, .tx_desc(), .tx_desc_valid(), .rx_out_sop());
   tx_sink sink (.stall, .tx_out_ready);
   always #12.5 mclk = ~mclk;
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'hD5 : 8'h00);
      return c;
   endfunction
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
   endtask
   task pkt(input logic x, input logic good);
      a = 8'($random(seed)); b = 8'($random(seed));
      fb.push_back(a); fb.push_back(b); fb.push_back(good ? crc(crc(8'h00, a), b) : ~crc(crc(8'h00, a), b));
      if (x) begin
         rq.push_back(a); rq.push_back(b); cq.push_back(good);
      end
   endtask
   task rx_frame(input logic ok, input logic [15:0] sd, input logic [15:0] df);
      @(posedge mclk);
      rx_hdr <= '{8'h00, 17'h18, df, sd, ok, 1'b1}; rx_hdr_valid <= 1;
      @(posedge mclk);
      rx_hdr_valid <= 0;
      foreach (fb[i]) begin
         rx_byte <= fb[i]; rx_byte_valid <= 1; @(posedge mclk);
      end
      rx_byte_valid <= 0; fb = {};
   endtask
   // ***************************************
   // watcher and timeout
   // ***************************************
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      stall <= 1'($random(seed));
      if (cyc == 20000) begin
         mismatches++; end_sim();
      end
      if (pready && !pwrite) begin
         e = aq.pop_front(); `CK("apb read", e, {pslverr, prdata})
      end
      if (tx_out_valid && tx_out_ready) begin
         e = tq.pop_front(); `CK("tx byte", e[8:0], tx_out)
      end
      if (rx_out_valid) begin
         e = rq.pop_front(); `CK("rx byte", e[7:0], rx_out_byte)
      end
      if (rx_pkt_done) begin
         e = cq.pop_front(); `CK("rx crc", e[0], rx_pkt_crc_ok)
      end
   end
   initial begin
      mclk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; stall = 0; in_level = 0;
      in_byte = 0; in_valid = 0; rx_hdr = '0; rx_hdr_valid = 0; rx_byte = 0; rx_byte_valid = 0;
      repeat (16) @(posedge mclk);
      sys_rst <= 0;
      foreach (ra[i]) begin
         aq.push_back(rv[i]); apb(0, ra[i], 32'h0);
      end
      apb(1, 12'h004, 32'h10); apb(1, 12'h008, 32'h10); apb(1, 12'h200, 32'h3); apb(1, 12'h000, 32'h3);
      // two short packets, each closes its own padded frame
      for (int i = 0; i < 2; i++) begin
         a = 8'($random(seed)); b = 8'($random(seed));
         tq.push_back({b, 1'b0}); tq.push_back({crc(8'h00, b), 1'b0}); tq.push_back({8'h00, 1'b1});
         @(posedge mclk); in_valid <= 1; in_byte <= a;
         @(posedge mclk); in_byte <= b;
      end
      @(posedge mclk); in_valid <= 0;
      while (tq.size() != 0) @(posedge mclk);
      pkt(1, 1); pkt(1, 0); rx_frame(1, 16'h10, 16'h30);
      pkt(0, 1); rx_frame(0, 16'h10, 16'h18);
      fb.push_back(8'($random(seed))); fb.push_back(8'($random(seed)));
      pkt(1, 1); fb.push_back(8'h00); rx_frame(1, 16'h08, 16'h28);
      repeat (8) @(posedge mclk);
      `CK("left over", 0, tq.size() + rq.size() + cq.size())
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
